// File: core/ltpd_pkg.sv
// Package for the logic trigger pulse detector: register map, mode codes,
// field layouts and reset values.
// Assumes a plain register port with word addresses equal to the map below.
package ltpd_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 32;
   localparam int          N_IN            = 3;
   // Register offsets (word addresses)
   localparam logic [15:0] OFS_MODE1       = 16'h9E3F;
   localparam logic [15:0] OFS_MODE2       = 16'h9E40;
   localparam logic [15:0] OFS_MODE3       = 16'h9E41;
   localparam logic [15:0] OFS_MAXWIDTH    = 16'hACA9;
   localparam logic [15:0] OFS_WIDTH1      = 16'hACB3;
   localparam logic [15:0] OFS_WIDTH2      = 16'hACB4;
   localparam logic [15:0] OFS_WIDTH3      = 16'hACB5;
   localparam logic [15:0] OFS_ORMASK      = 16'hA000;
   localparam logic [15:0] OFS_CTRL        = 16'hA001;
   localparam logic [15:0] OFS_IRQ_STAT    = 16'hA002;
   localparam logic [15:0] OFS_IRQ_MASK    = 16'hA003;
   localparam logic [15:0] OFS_STATUS      = 16'hA004;
   // Mode codes
   localparam logic [31:0] MODE_OFF        = 32'h0000_0000;
   localparam logic [31:0] MODE_RISE       = 32'h0000_0001;
   localparam logic [31:0] MODE_FALL       = 32'h0000_0002;
   localparam logic [31:0] MODE_BOTH       = 32'h0000_0004;
   localparam logic [31:0] MODE_HIGH       = 32'h0000_0008;
   localparam logic [31:0] MODE_LOW        = 32'h0000_0010;
   localparam logic [31:0] MODE_HI_LONG    = 32'h0400_0001;
   localparam logic [31:0] MODE_HI_SHORT   = 32'h0200_0001;
   localparam logic [31:0] MODE_LO_LONG    = 32'h0400_0002;
   localparam logic [31:0] MODE_LO_SHORT   = 32'h0200_0002;
   // OR mask bit positions
   localparam int          ORM_IN1_BIT     = 2;
   localparam int          ORM_IN2_BIT     = 3;
   localparam int          ORM_IN3_BIT     = 4;
   // Control register bits (start and done are one-shot commands; stretch is held)
   localparam int          CTRL_START_BIT  = 0;
   localparam int          CTRL_DONE_BIT   = 1;
   localparam int          CTRL_STRETCH_BIT = 2;
   // Interrupt status bits
   localparam int          IRQ_TRIG_BIT    = 0;
   localparam int          IRQ_IGN_BIT     = 1;
   // Reset values and capability
   localparam logic [31:0] RST_MODE        = 32'h0000_0000;
   localparam logic [31:0] RST_WIDTH       = 32'h0000_0002;
   localparam logic [31:0] RST_ORMASK      = 32'h0000_0000;
   localparam logic [31:0] MAX_WIDTH_VAL   = 32'hFFFF_FFFF;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_REPLAY} ltpd_state_t;
endpackage : ltpd_pkg

// File: core/ltpd_top.sv
// Logic trigger pulse detector for three external logic inputs.
// Assumes the inputs are asynchronous pins and a one-cycle register port.
// Behaviour
// - Mode 2h: trigger on first falling edge
// - Ignore triggers until replay done, rearmed
// - Optional stretch catches short edge pulses
// - Mode 10h: trigger on first low level
// - Level already true at start triggers immediately
// - Mode 4h: trigger on either edge
// - 4000001h: high pulse longer than width
// - 2000001h: high pulse shorter than width
// - 4000002h: low pulse longer than width
// - 2000002h: low pulse shorter than width
// - Per-input width, software programs 2..4G-1
// - Width modes fire on first qualifying pulse
// - Read-only common maximum width value
// - OR mask bits 4h, 8h, 10h
// - 1h rising, 8h high, 0h off
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ltpd_top
   import ltpd_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_nrst,
   input  wire logic [N_IN-1:0]   i_trig_in,
   input  wire logic [15:0]       i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   output logic                   o_trigger,
   output logic                   o_armed,
   output logic                   o_irq
);
   logic [31:0]      mode_r  [N_IN];
   logic [31:0]      width_r [N_IN];
   logic [31:0]      cnt_r   [N_IN];
   logic [N_IN-1:0]  sync1_r, sync2_r, prev_r, hit;
   logic [N_IN-1:0]  stretch_r;
   logic [31:0]      ormask_r;
   logic             stretch_en_r;
   logic [1:0]       irq_stat_r, irq_mask_r;
   logic [31:0]      rdata_r;
   logic             trig_r, irq_r;
   ltpd_state_t      state_r, state_nxt;

   // Register port decode
   wire wr_mode1  = i_wr && (i_addr == OFS_MODE1);
   wire wr_mode2  = i_wr && (i_addr == OFS_MODE2);
   wire wr_mode3  = i_wr && (i_addr == OFS_MODE3);
   wire wr_wid1   = i_wr && (i_addr == OFS_WIDTH1);
   wire wr_wid2   = i_wr && (i_addr == OFS_WIDTH2);
   wire wr_wid3   = i_wr && (i_addr == OFS_WIDTH3);
   wire wr_ormask = i_wr && (i_addr == OFS_ORMASK);
   wire wr_ctrl   = i_wr && (i_addr == OFS_CTRL);
   wire wr_imask  = i_wr && (i_addr == OFS_IRQ_MASK);
   wire rd_istat  = i_rd && (i_addr == OFS_IRQ_STAT);
   wire cmd_start = wr_ctrl && i_wdata[CTRL_START_BIT];
   wire cmd_done  = wr_ctrl && i_wdata[CTRL_DONE_BIT];
   wire [N_IN-1:0] wr_mode = {wr_mode3, wr_mode2, wr_mode1};
   wire [N_IN-1:0] wr_wid  = {wr_wid3, wr_wid2, wr_wid1};
   wire [N_IN-1:0] or_en   = {ormask_r[ORM_IN3_BIT], ormask_r[ORM_IN2_BIT],
                              ormask_r[ORM_IN1_BIT]};
   wire armed     = (state_r == ST_ARMED);
   // First armed cycle lets level modes see a level present at start
   wire any_hit   = armed && |(hit & or_en);
   wire ignored   = (state_r == ST_REPLAY) && |(hit & or_en);

   // Two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end else begin
         sync1_r <= i_trig_in;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Per-input detection; one shared generate keeps the three lanes identical
   for (genvar g = 0; g < N_IN; g++) begin : g_lane
      wire lvl   = sync2_r[g] | (stretch_en_r & stretch_r[g]);
      // Edges compare against the conditioned level, not the raw sample:
      // with stretch on, the raw previous sample would mask every fall
      logic lvl_d;
      wire rise  = lvl & ~lvl_d;
      wire fall  = ~lvl & lvl_d;
      // Counter holds the length of the current pulse in sample periods
      wire hi_on = (mode_r[g] == MODE_HI_LONG) || (mode_r[g] == MODE_HI_SHORT);
      wire in_p  = hi_on ? lvl : ~lvl;
      wire p_end = hi_on ? fall : rise;
      wire p_beg = hi_on ? rise : fall;
      wire over  = (cnt_r[g] > width_r[g]);
      always_comb begin
         case (mode_r[g])
            MODE_RISE:     hit[g] = rise;
            MODE_FALL:     hit[g] = fall;
            MODE_BOTH:     hit[g] = rise | fall;
            MODE_HIGH:     hit[g] = lvl;
            MODE_LOW:      hit[g] = ~lvl;
            // Count holds the samples before this one, so equality with the
            // width means this is sample width+1 of the pulse
            MODE_HI_LONG,
            MODE_LO_LONG:  hit[g] = in_p && (cnt_r[g] == width_r[g])
                                    && !p_beg;
            // Shorter-than fires at the end edge
            MODE_HI_SHORT,
            MODE_LO_SHORT: hit[g] = p_end && (cnt_r[g] != 32'h0000_0000)
                                    && (cnt_r[g] < width_r[g]);
            default:       hit[g] = 1'b0;
         endcase
      end
      // Count pulse length; saturates at the top so wrap can not fake a hit
      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) begin
            cnt_r[g] <= '0;
         end else if (!in_p || p_beg) begin
            cnt_r[g] <= in_p ? 32'h0000_0001 : 32'h0000_0000;
         end else if (!over || cnt_r[g] != MAX_WIDTH_VAL) begin
            cnt_r[g] <= (cnt_r[g] == MAX_WIDTH_VAL) ? cnt_r[g]
                        : cnt_r[g] + 32'h0000_0001;
         end
      end
      // Stretch holds a sampled high one extra cycle
      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) stretch_r[g] <= 1'b0;
         else         stretch_r[g] <= sync2_r[g];
      end
      // Previous conditioned level for the edge detectors
      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) lvl_d <= 1'b0;
         else         lvl_d <= lvl;
      end
      // Mode and width registers
      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) begin
            mode_r[g]  <= RST_MODE;
            width_r[g] <= RST_WIDTH;
         end else begin
            if (wr_mode[g]) mode_r[g]  <= i_wdata;
            if (wr_wid[g])  width_r[g] <= i_wdata;
         end
      end
   end

   // Arm sequencer: start arms, trigger moves to replay, done re-arms
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:   if (cmd_start) state_nxt = ST_ARMED;
         ST_ARMED:  if (any_hit)   state_nxt = ST_REPLAY;
         ST_REPLAY: if (cmd_done)  state_nxt = ST_ARMED;
         default:   state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= ST_IDLE;
         trig_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         trig_r  <= any_hit;
      end
   end

   // Control registers
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ormask_r     <= RST_ORMASK;
         stretch_en_r <= 1'b0;
         irq_mask_r   <= '0;
      end else begin
         if (wr_ormask) ormask_r <= i_wdata;
         if (wr_ctrl)   stretch_en_r <= i_wdata[CTRL_STRETCH_BIT];
         if (wr_imask)  irq_mask_r <= i_wdata[1:0];
      end
   end

   // Sticky events; set wins over read-clear
   wire [1:0] ev = {ignored, any_hit};
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_stat_r <= '0;
         irq_r      <= 1'b0;
      end else begin
         irq_stat_r <= (rd_istat ? 2'h0 : irq_stat_r) | ev;
         irq_r      <= |((((rd_istat ? 2'h0 : irq_stat_r) | ev)) & irq_mask_r);
      end
   end

   // Read mux; unmapped addresses read zero
   logic [31:0] rd_mux;
   always_comb begin
      case (i_addr)
         OFS_MODE1:    rd_mux = mode_r[0];
         OFS_MODE2:    rd_mux = mode_r[1];
         OFS_MODE3:    rd_mux = mode_r[2];
         OFS_WIDTH1:   rd_mux = width_r[0];
         OFS_WIDTH2:   rd_mux = width_r[1];
         OFS_WIDTH3:   rd_mux = width_r[2];
         OFS_MAXWIDTH: rd_mux = MAX_WIDTH_VAL;
         OFS_ORMASK:   rd_mux = ormask_r;
         OFS_CTRL:     rd_mux = {29'h0, stretch_en_r, 2'h0};
         OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_r};
         OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_r};
         OFS_STATUS:   rd_mux = {27'h0, sync2_r, state_r};
         default:      rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) rdata_r <= '0;
      else         rdata_r <= i_rd ? rd_mux : 32'h0000_0000;
   end

   // Outputs come from flops
   logic armed_r;
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) armed_r <= 1'b0;
      else         armed_r <= (state_nxt == ST_ARMED);
   end
   assign o_rdata   = rdata_r;
   assign o_trigger = trig_r;
   assign o_armed   = armed_r;
   assign o_irq     = irq_r;

   // Assertions
   AST_TRIG_ONLY_ARMED: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_trigger |-> $past(state_r) == ST_ARMED) else $error("trigger while not armed");
   AST_NO_RETRIG: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_trigger |=> !o_trigger) else $error("second trigger without rearm");
   AST_FALL: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (armed && mode_r[0] == MODE_FALL && or_en[0] && !sync2_r[0] && prev_r[0] && !stretch_en_r)
      |=> o_trigger) else $error("falling edge missed");
   AST_LOW: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (armed && mode_r[0] == MODE_LOW && or_en[0] && !sync2_r[0] && !stretch_en_r)
      |=> o_trigger) else $error("low level missed");
   AST_BOTH: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (armed && mode_r[1] == MODE_BOTH && or_en[1] && (sync2_r[1] != prev_r[1]) && !stretch_en_r)
      |=> o_trigger) else $error("edge missed");
   AST_MASKED: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (ormask_r == 32'h0000_0000) |=> !o_trigger) else $error("trigger with empty mask");
   AST_MAXW: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_rd && i_addr == OFS_MAXWIDTH) |=> o_rdata == MAX_WIDTH_VAL) else $error("bad max width");
   AST_SYNC: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      sync2_r == $past(i_trig_in, 2) || $past(!i_nrst, 2)) else $error("sync depth wrong");
   AST_REARM: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (state_r == ST_REPLAY && cmd_done) |=> state_r == ST_ARMED) else $error("no rearm");
   COV_TRIG:  cover property (@(posedge i_mclk) disable iff (!i_nrst) o_trigger);
   COV_IGN:   cover property (@(posedge i_mclk) disable iff (!i_nrst) ignored);
   COV_LONG:  cover property (@(posedge i_mclk) disable iff (!i_nrst)
      any_hit && mode_r[0] == MODE_HI_LONG);
   COV_SHORT: cover property (@(posedge i_mclk) disable iff (!i_nrst)
      any_hit && mode_r[0] == MODE_LO_SHORT);
endmodule : ltpd_top
`default_nettype wire

// File: verif/ltpd_src.sv
// Source model for the three external logic trigger pins.
// Assumes the bench calls its tasks and shares the sample clock.
`timescale 1ns/10ps
`default_nettype none
module ltpd_src
   import ltpd_pkg::*;
(
   input  wire logic            i_mclk,
   output var  logic [N_IN-1:0] o_pin
);
   // Pins rest high, as an open logic input with a pull-up would
   initial o_pin = '1;
   // Level change launched just after a clock edge, never on it
   task automatic set_pin(input int idx, input logic lvl);
      @(posedge i_mclk);
      o_pin[idx] <= lvl;
   endtask : set_pin
   // Pulse of whole clock cycles; the pin then returns to the other level
   task automatic pulse(input int idx, input logic lvl, input int len);
      set_pin(idx, lvl);
      repeat (len) @(posedge i_mclk);
      o_pin[idx] <= ~lvl;
   endtask : pulse
endmodule : ltpd_src
`default_nettype wire

// File: verif/ltpd_top_tb_top.sv
// Self-checking bench for the logic trigger pulse detector.
// Assumes ltpd_src drives the pins; assertions live inside the design.
`timescale 1ns/10ps
`default_nettype none
module ltpd_top_tb_top
   import ltpd_pkg::*;
();
   localparam int W = 4;
   logic            i_mclk = 1'b0;
   logic            i_nrst = 1'b0;
   logic [N_IN-1:0] pins;
   logic [15:0]     i_addr = 16'h0000;
   logic [31:0]     i_wdata = 32'h0000_0000;
   logic            i_wr = 1'b0;
   logic            i_rd = 1'b0;
   logic [31:0]     o_rdata;
   logic            o_trigger;
   logic            o_armed;
   logic            o_irq;
   int              num_errors = 0;
   int              checks_done = 0;
   int              trig_cnt = 0;
   int              cyc = 0;
   ltpd_top ltpd_top_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_trig_in(pins), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_trigger(o_trigger), .o_armed(o_armed), .o_irq(o_irq));
   ltpd_src ltpd_src_i (.i_mclk(i_mclk), .o_pin(pins));
   // 200 MHz sample clock
   initial forever #2.5 i_mclk = ~i_mclk;
   // Trigger pulses are counted here so scenarios never miss a one-cycle pulse
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (o_trigger === 1'b1) trig_cnt <= trig_cnt + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         $display("timeout after %0d cycles", cyc);
         end_of_test;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic ticks(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : ticks
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : rd
   task automatic ctrig(input string what, input int n, input logic [31:0] e);
      check(what, 32'(trig_cnt - n), e);
   endtask : ctrig
   task automatic arm(input int idx, input logic [31:0] mode);
      wr(16'(OFS_MODE1 + idx), mode);
      wr(OFS_ORMASK, 32'h4 << idx);
      wr(OFS_CTRL, 32'h1);
   endtask : arm
   task automatic t_regs;
      logic [31:0] v;
      for (int k = 0; k < 3; k++) begin
         rd(16'(OFS_MODE1 + k), v);
         check("mode reset", v, 32'h0);
         rd(16'(OFS_WIDTH1 + k), v);
         check("width reset", v, RST_WIDTH);
      end
      wr(OFS_MAXWIDTH, 32'h0);
      rd(OFS_MAXWIDTH, v);
      check("max width", v, 32'hFFFF_FFFF);
      wr(OFS_WIDTH2, 32'hFFFF_FFFF);
      rd(OFS_WIDTH2, v);
      check("width top", v, 32'hFFFF_FFFF);
      rd(16'h1234, v);
      check("unmapped", v, 32'h0);
      $display("test regs done");
   endtask : t_regs
   // Runs after t_regs while still idle: the pin goes low before start arms, so the level is present at start
   task automatic t_low;
      int n;
      ltpd_src_i.set_pin(1, 1'b0);
      ticks(4);
      n = trig_cnt;
      arm(1, MODE_LOW);
      ticks(6);
      ctrig("low at start", n, 32'h1);
      ltpd_src_i.set_pin(1, 1'b1);
      ticks(4);
      wr(OFS_CTRL, 32'h2);
      $display("test low done");
   endtask : t_low
   task automatic t_fall;
      int n;
      logic [31:0] v;
      rd(OFS_IRQ_STAT, v);
      wr(OFS_IRQ_MASK, 32'h1);
      arm(0, MODE_FALL);
      ticks(2);
      check("armed", {31'h0, o_armed}, 32'h1);
      n = trig_cnt;
      ltpd_src_i.set_pin(0, 1'b0);
      ticks(6);
      ctrig("fall", n, 32'h1);
      check("irq", {31'h0, o_irq}, 32'h1);
      ltpd_src_i.set_pin(0, 1'b1);
      ticks(3);
      ltpd_src_i.set_pin(0, 1'b0);
      ticks(6);
      ctrig("fall in replay", n, 32'h1);
      rd(OFS_IRQ_STAT, v);
      check("irq stat", v, 32'h3);
      ticks(2);
      check("irq cleared", {31'h0, o_irq}, 32'h0);
      wr(OFS_CTRL, 32'h2);
      ticks(2);
      check("rearmed", {31'h0, o_armed}, 32'h1);
      ltpd_src_i.set_pin(0, 1'b1);
      ticks(3);
      ltpd_src_i.set_pin(0, 1'b0);
      ticks(6);
      ctrig("fall after rearm", n, 32'h2);
      wr(OFS_CTRL, 32'h2);
      $display("test fall done");
   endtask : t_fall
   task automatic t_both;
      int n;
      arm(2, MODE_BOTH);
      n = trig_cnt;
      ltpd_src_i.set_pin(2, 1'b0);
      ticks(6);
      ctrig("both fall", n, 32'h1);
      wr(OFS_CTRL, 32'h2);
      ltpd_src_i.set_pin(2, 1'b1);
      ticks(6);
      ctrig("both rise", n, 32'h2);
      wr(OFS_CTRL, 32'h2);
      arm(2, MODE_OFF);
      n = trig_cnt;
      ltpd_src_i.set_pin(2, 1'b0);
      ticks(4);
      ltpd_src_i.set_pin(2, 1'b1);
      ticks(6);
      ctrig("off", n, 32'h0);
      wr(OFS_MODE3, MODE_FALL);
      wr(OFS_ORMASK, 32'h0);
      ltpd_src_i.set_pin(2, 1'b0);
      ticks(6);
      ctrig("not in mask", n, 32'h0);
      arm(2, MODE_RISE);
      ltpd_src_i.set_pin(2, 1'b1);
      ticks(6);
      ctrig("rise", n, 32'h1);
      wr(OFS_MODE3, MODE_HIGH);
      wr(OFS_CTRL, 32'h2);
      ticks(4);
      ctrig("high level", n, 32'h2);
      wr(OFS_MODE3, MODE_OFF);
      wr(OFS_CTRL, 32'h2);
      $display("test both done");
   endtask : t_both
   // Boundary pulses: exactly W never qualifies, W+1 or W-1 does
   task automatic t_width;
      int n;
      logic lvl;
      logic [31:0] md [4];
      md = '{MODE_HI_LONG, MODE_HI_SHORT, MODE_LO_LONG, MODE_LO_SHORT};
      wr(OFS_WIDTH1, 32'(W));
      for (int k = 0; k < 4; k++) begin
         lvl = (k < 2);
         wr(OFS_MODE1, MODE_OFF);
         ltpd_src_i.set_pin(0, ~lvl);
         ticks(4);
         arm(0, md[k]);
         n = trig_cnt;
         ltpd_src_i.pulse(0, lvl, W);
         ticks(8);
         ctrig("width reject", n, 32'h0);
         ltpd_src_i.pulse(0, lvl, (k % 2 == 0) ? W + 1 : W - 1);
         ticks(8);
         ctrig("width accept", n, 32'h1);
         wr(OFS_CTRL, 32'h2);
      end
      $display("test width done");
   endtask : t_width
   // One-sample high pulse with stretch on must still give a falling edge
   task automatic t_stretch;
      int n;
      ltpd_src_i.set_pin(0, 1'b0);
      ticks(4);
      arm(0, MODE_FALL);
      wr(OFS_CTRL, 32'h4);
      ticks(4);
      n = trig_cnt;
      ltpd_src_i.pulse(0, 1'b1, 1);
      ticks(8);
      ctrig("stretched fall", n, 32'h1);
      wr(OFS_CTRL, 32'h2);
      $display("test stretch done");
   endtask : t_stretch
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial begin
      repeat (8) @(posedge i_mclk);
      i_nrst <= 1'b1;
      t_regs;
      t_low;
      t_fall;
      t_both;
      t_width;
      t_stretch;
      end_of_test;
   end
endmodule : ltpd_top_tb_top
`default_nettype wire
